// ---- hw/bus_cycle_sequencer.sv ----
// Machine-cycle bus sequencer for an 8-bit processor core.
// Assumes the core requests one sequence at a time on START while READY
// is high; DATA_IN and BUS_REQ_N come from pins and are synchronised.
`timescale 1ns/100ps
`default_nettype none

module bus_cycle_sequencer
    import bus_seq_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        START,
    input  wire logic [2:0]  SEQ_SEL,
    input  wire logic        COND_TRUE,
    input  wire logic [15:0] PC,
    input  wire logic [15:0] SP,
    input  wire logic [15:0] STORE_WORD,
    input  wire logic [7:0]  VECTOR_BASE,
    input  wire logic [7:0]  INT_VECTOR,
    input  wire logic [7:0]  DATA_IN,
    input  wire logic        BUS_REQ_N,
    input  wire logic        REFRESH_REQ,
    output var  logic [15:0] ADDR,
    output var  logic [7:0]  DATA_OUT,
    output var  logic        DATA_OE,
    output var  logic        RD_N,
    output var  logic        WR_N,
    output var  logic        MEMORY_REQUEST_N,
    output var  logic        IO_REQUEST_N,
    output var  logic        OPCODE_CYCLE_N,
    output var  logic        HALT_N,
    output var  logic        STATUS_OUT,
    output var  logic        BUS_ACK_N,
    output var  logic        REFRESH_N,
    output var  logic        READY,
    output var  logic [15:0] CAPTURED_WORD
);

    // Which machine cycle a sequence runs at a given step
    function automatic mc_type step(input seq_type s, input logic [2:0] i,
                                    input logic c);
        mc_type r;
        r = MC_NONE;
        case (s)
            SEQ_ST_HL: begin
                case (i)
                    3'h0: r = MC_FETCH1;
                    3'h1, 3'h2: r = MC_OPND;
                    3'h3: r = MC_IDLE;
                    3'h4: r = MC_WR_MN;
                    3'h5: r = MC_WR_MN1;
                    default: r = MC_NONE;
                endcase
            end
            SEQ_ST_PAIR: begin
                case (i)
                    3'h0: r = MC_FETCH1;
                    3'h1: r = MC_FETCH2;
                    3'h2, 3'h3: r = MC_OPND;
                    3'h4: r = MC_IDLE;
                    3'h5: r = MC_WR_MN;
                    3'h6: r = MC_WR_MN1;
                    default: r = MC_NONE;
                endcase
            end
            SEQ_PUSH_IDX: begin
                case (i)
                    3'h0: r = MC_FETCH1;
                    3'h1: r = MC_FETCH2;
                    3'h2, 3'h3: r = MC_IDLE;
                    3'h4: r = MC_WR_SP1;
                    3'h5: r = MC_WR_SP2;
                    default: r = MC_NONE;
                endcase
            end
            SEQ_RET: begin
                case (i)
                    3'h0: r = MC_FETCH1;
                    3'h1: r = MC_RD_SP;
                    3'h2: r = MC_RD_SP1;
                    default: r = MC_NONE;
                endcase
            end
            SEQ_RET_COND: begin
                case (i)
                    3'h0: r = MC_FETCH1;
                    3'h1: r = MC_IDLE;
                    3'h2: r = c ? MC_RD_SP : MC_IDLE;
                    3'h3: r = c ? MC_RD_SP1 : MC_NONE;
                    default: r = MC_NONE;
                endcase
            end
            SEQ_RETURN_FROM_INTERRUPT: begin
                case (i)
                    3'h0: r = MC_FETCH1;
                    3'h1: r = MC_FETCH2;
                    3'h2: r = MC_RD_SPH;
                    3'h3: r = MC_RD_SP1;
                    default: r = MC_NONE;
                endcase
            end
            default: begin
                case (i)
                    3'h0: r = (s == SEQ_EXT_INT_ZERO) ? MC_ACK : MC_INTRESP;
                    3'h1: r = MC_IDLE;
                    3'h2: r = MC_WR_SP1;
                    3'h3: r = MC_WR_SP2;
                    3'h4: r = MC_RD_VEC;
                    3'h5: r = MC_RD_VEC1;
                    default: r = MC_NONE;
                endcase
            end
        endcase
        return r;
    endfunction : step

    // Pin synchronisers; first stages feed only the second stages
    logic [7:0] din_meta_reg;
    logic [7:0] din_sync_reg;
    logic       breq_meta_reg;
    logic       breq_sync_reg;

    always_ff @(posedge CLK) begin
        din_meta_reg  <= DATA_IN;
        din_sync_reg  <= din_meta_reg;
        breq_meta_reg <= ~BUS_REQ_N;
        breq_sync_reg <= breq_meta_reg;
    end

    phase_type   phase_reg, phase_next;
    mc_type      mc_reg, mc_next;
    seq_type     seq_reg, seq_next;
    logic [2:0]  idx_reg, idx_next, tcnt_reg, tcnt_next;
    logic        cond_reg, cond_next, pend_reg, pend_next;
    logic [1:0]  cap_reg, cap_next;
    logic [15:0] fptr_reg, fptr_next, sp_reg, sp_next;
    logic [15:0] store_reg, store_next, capt_reg, capt_next;
    logic [7:0]  base_reg, base_next, vec_reg, vec_next, ivec_reg, ivec_next;
    logic [15:0] addr_next, vaddr;
    logic [7:0]  dout_next;
    logic [6:0]  stb_next;
    logic        start_ok, mc_end;

    // Bus request outranks refresh, refresh outranks a new sequence
    assign start_ok = (phase_reg == PH_READY) && !breq_sync_reg && !pend_reg;
    assign mc_end   = (phase_reg == PH_RUN) && (tcnt_reg == 3'h0);
    assign vaddr    = {base_reg, vec_reg};

    // Sequencing, operand capture and arbitration
    always_comb begin
        phase_next = phase_reg;
        mc_next    = mc_reg;
        seq_next   = seq_reg;
        idx_next   = idx_reg;
        tcnt_next  = tcnt_reg;
        cond_next  = cond_reg;
        fptr_next  = fptr_reg;
        sp_next    = sp_reg;
        store_next = store_reg;
        base_next  = base_reg;
        ivec_next  = ivec_reg;
        vec_next   = vec_reg;
        capt_next  = capt_reg;
        cap_next   = 2'h0;
        pend_next  = pend_reg | REFRESH_REQ;
        // Reads land one cycle after T3, past the synchroniser delay
        if (cap_reg == 2'h1)
            capt_next = {din_sync_reg, capt_reg[15:8]};
        else if (cap_reg == 2'h2)
            vec_next = din_sync_reg;
        case (phase_reg)
            PH_READY: begin
                if (breq_sync_reg) begin
                    phase_next = PH_GRANT;
                    pend_next  = 1'b0;
                end else if (pend_reg) begin
                    phase_next = PH_REFRESH;
                    pend_next  = REFRESH_REQ;
                end else if (START) begin
                    seq_next   = seq_type'(SEQ_SEL);
                    cond_next  = COND_TRUE;
                    fptr_next  = PC;
                    sp_next    = SP;
                    base_next  = VECTOR_BASE;
                    ivec_next  = INT_VECTOR;
                    vec_next   = INT_VECTOR;
                    store_next = (SEQ_SEL[2:1] == 2'h3) ? PC : STORE_WORD;
                    idx_next   = 3'h0;
                    mc_next    = step(seq_type'(SEQ_SEL), 3'h0, COND_TRUE);
                    phase_next = PH_RUN;
                end
            end
            PH_RUN: begin
                if (mc_end) begin
                    if (mc_reg == MC_FETCH1 || mc_reg == MC_FETCH2 ||
                        mc_reg == MC_OPND)
                        fptr_next = fptr_reg + 16'h0001;
                    if (mc_reg == MC_ACK)
                        cap_next = 2'h2;
                    else if (STB_READ == (step_stb(mc_reg) | 7'h02) &&
                             mc_reg != MC_FETCH1 && mc_reg != MC_FETCH2)
                        cap_next = 2'h1;
                    idx_next = idx_reg + 3'h1;
                    mc_next  = step(seq_reg, idx_reg + 3'h1, cond_reg);
                    if (mc_next == MC_NONE)
                        phase_next = PH_READY;
                end
            end
            PH_GRANT: begin
                if (!breq_sync_reg)
                    phase_next = PH_READY;
            end
            default: phase_next = PH_READY;
        endcase
        if (phase_next != PH_RUN)
            mc_next = MC_NONE;
        case (mc_next)
            MC_IDLE:    tcnt_next = T_IDLE_LAST;
            MC_ACK,
            MC_INTRESP: tcnt_next = T_ACK_LAST;
            default:    tcnt_next = (phase_reg == PH_RUN && !mc_end) ?
                                    tcnt_reg - 3'h1 : T_MEM_LAST;
        endcase
        if (phase_reg == PH_RUN && !mc_end)
            tcnt_next = tcnt_reg - 3'h1;
    end

    function automatic logic [6:0] step_stb(input mc_type m);
        logic [6:0] s;
        s = STB_QUIET;
        case (m)
            MC_FETCH1:  s = STB_FETCH1;
            MC_FETCH2:  s = STB_FETCH2;
            MC_OPND, MC_RD_SP, MC_RD_SP1,
            MC_RD_VEC, MC_RD_VEC1: s = STB_READ;
            MC_RD_SPH:  s = STB_RD_HALT;
            MC_WR_MN, MC_WR_MN1,
            MC_WR_SP1, MC_WR_SP2: s = STB_WRITE;
            MC_ACK:     s = STB_ACK;
            MC_INTRESP: s = STB_INTRESP;
            default:    s = STB_QUIET;
        endcase
        return s;
    endfunction : step_stb

    // Address and write data for the coming machine cycle
    always_comb begin
        stb_next  = step_stb(mc_next);
        dout_next = BYTE_RESET;
        addr_next = ADDR_RESET;
        case (mc_next)
            MC_FETCH1, MC_FETCH2, MC_OPND: addr_next = fptr_next;
            MC_ACK, MC_INTRESP: addr_next = fptr_next;
            MC_WR_MN: begin
                addr_next = capt_next;
                dout_next = store_reg[7:0];
            end
            MC_WR_MN1: begin
                addr_next = capt_next + 16'h0001;
                dout_next = store_reg[15:8];
            end
            MC_WR_SP1: begin
                addr_next = sp_reg - 16'h0001;
                dout_next = store_reg[15:8];
            end
            MC_WR_SP2: begin
                addr_next = sp_reg - 16'h0002;
                dout_next = store_reg[7:0];
            end
            MC_RD_SP, MC_RD_SPH: addr_next = sp_reg;
            MC_RD_SP1: addr_next = sp_reg + 16'h0001;
            MC_RD_VEC:  addr_next = vaddr;
            MC_RD_VEC1: addr_next = vaddr + 16'h0001;
            default: addr_next = ADDR_RESET;
        endcase
    end

    // State and pin registers; every output is a flop
    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_reg <= PH_READY;
            mc_reg    <= MC_NONE;
            seq_reg   <= SEQ_ST_HL;
            idx_reg   <= 3'h0;
            tcnt_reg  <= 3'h0;
            cond_reg  <= 1'b0;
            pend_reg  <= 1'b0;
            cap_reg   <= 2'h0;
            fptr_reg  <= ADDR_RESET;
            sp_reg    <= ADDR_RESET;
            store_reg <= ADDR_RESET;
            capt_reg  <= ADDR_RESET;
            base_reg  <= BYTE_RESET;
            vec_reg   <= BYTE_RESET;
            ivec_reg  <= BYTE_RESET;
            ADDR      <= ADDR_RESET;
            DATA_OUT  <= BYTE_RESET;
            DATA_OE   <= 1'b0;
            {RD_N, WR_N, MEMORY_REQUEST_N, IO_REQUEST_N,
             OPCODE_CYCLE_N, HALT_N, STATUS_OUT} <= STB_QUIET;
            BUS_ACK_N <= 1'b1;
            REFRESH_N <= 1'b1;
            READY     <= 1'b1;
            CAPTURED_WORD <= ADDR_RESET;
        end else begin
            phase_reg <= phase_next;
            mc_reg    <= mc_next;
            seq_reg   <= seq_next;
            idx_reg   <= idx_next;
            tcnt_reg  <= tcnt_next;
            cond_reg  <= cond_next;
            pend_reg  <= pend_next;
            cap_reg   <= cap_next;
            fptr_reg  <= fptr_next;
            sp_reg    <= sp_next;
            store_reg <= store_next;
            capt_reg  <= capt_next;
            base_reg  <= base_next;
            vec_reg   <= vec_next;
            ivec_reg  <= ivec_next;
            ADDR      <= addr_next;
            DATA_OUT  <= dout_next;
            DATA_OE   <= ~stb_next[5];
            {RD_N, WR_N, MEMORY_REQUEST_N, IO_REQUEST_N,
             OPCODE_CYCLE_N, HALT_N, STATUS_OUT} <= stb_next;
            BUS_ACK_N <= ~(phase_next == PH_GRANT);
            REFRESH_N <= ~(phase_next == PH_REFRESH);
            READY     <= (phase_next == PH_READY);
            CAPTURED_WORD <= capt_next;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_two_idle;
        (mc_reg == MC_IDLE) ##1 (mc_reg == MC_IDLE);
    endsequence

    a_fetch_strobes: assert property (mc_reg == MC_FETCH1 |->
        !RD_N && WR_N && !MEMORY_REQUEST_N && IO_REQUEST_N &&
        !OPCODE_CYCLE_N && HALT_N && ADDR == fptr_reg)
        else $error("fetch strobes wrong");
    a_status_first: assert property (!STATUS_OUT |->
        (mc_reg == MC_FETCH1 && idx_reg == 3'h0) ||
        mc_reg == MC_ACK || mc_reg == MC_INTRESP)
        else $error("status low outside first cycle");
    a_idle_quiet: assert property (mc_reg == MC_IDLE |->
        RD_N && WR_N && MEMORY_REQUEST_N && IO_REQUEST_N &&
        OPCODE_CYCLE_N && HALT_N && STATUS_OUT && !DATA_OE)
        else $error("idle state not quiet");
    a_high_write: assert property ($rose(mc_reg == MC_WR_MN1) |->
        ADDR == capt_reg + 16'h0001 && DATA_OUT == store_reg[15:8] &&
        $past(mc_reg == MC_WR_MN, 1))
        else $error("second store byte wrong");
    a_push_order: assert property ($rose(mc_reg == MC_WR_SP1) |->
        ADDR == sp_reg - 16'h0001 ##3 mc_reg == MC_WR_SP2 &&
        ADDR == sp_reg - 16'h0002 && DATA_OUT == store_reg[7:0])
        else $error("push order wrong");
    a_return_from_interrupt_halt: assert property (!HALT_N |->
        !RD_N && ADDR == sp_reg && $past(mc_reg == MC_FETCH2, 3))
        else $error("halt low at wrong place");
    a_ack_len: assert property ($rose(!IO_REQUEST_N) |->
        (!IO_REQUEST_N && !OPCODE_CYCLE_N && MEMORY_REQUEST_N)[*5]
        ##1 mc_reg == MC_IDLE)
        else $error("acknowledge length wrong");
    a_false_ret: assert property (START && start_ok &&
        SEQ_SEL == SEQ_RET_COND && !COND_TRUE |->
        ##1 (mc_reg == MC_FETCH1)[*3] ##1 s_two_idle ##1 READY && RD_N)
        else $error("false return did not end");
    a_bus_first: assert property (phase_reg == PH_READY &&
        breq_sync_reg |=> !BUS_ACK_N && !pend_reg)
        else $error("bus request not granted first");

endmodule : bus_cycle_sequencer

`default_nettype wire

// ---- hw/bus_seq_pkg.sv ----
// Constants and types for the machine-cycle bus sequencer.
// Assumes one clock domain at 125 MHz and a synchronous reset.
package bus_seq_pkg;

    // Machine cycle kinds; fetch, operand and acknowledge cycles share the fetch pointer
    typedef enum logic [3:0] {
        MC_NONE     = 4'h0,
        MC_FETCH1   = 4'h1,
        MC_FETCH2   = 4'h2,
        MC_OPND     = 4'h3,
        MC_IDLE     = 4'h4,
        MC_WR_MN    = 4'h5,
        MC_WR_MN1   = 4'h6,
        MC_WR_SP1   = 4'h7,
        MC_WR_SP2   = 4'h8,
        MC_RD_SP    = 4'h9,
        MC_RD_SPH   = 4'hA,
        MC_RD_SP1   = 4'hB,
        MC_ACK      = 4'hC,
        MC_INTRESP  = 4'hD,
        MC_RD_VEC   = 4'hE,
        MC_RD_VEC1  = 4'hF
    } mc_type;

    // Instruction and interrupt sequences
    typedef enum logic [2:0] {
        SEQ_ST_HL    = 3'h0,
        SEQ_ST_PAIR  = 3'h1,
        SEQ_PUSH_IDX = 3'h2,
        SEQ_RET      = 3'h3,
        SEQ_RET_COND = 3'h4,
        SEQ_RETURN_FROM_INTERRUPT     = 3'h5,
        SEQ_EXT_INT_ZERO     = 3'h6,
        SEQ_INT_OTH  = 3'h7
    } seq_type;

    typedef enum logic [1:0] {
        PH_READY   = 2'h0,
        PH_RUN     = 2'h1,
        PH_GRANT   = 2'h2,
        PH_REFRESH = 2'h3
    } phase_type;

    // States per machine cycle, as counts minus one
    localparam logic [2:0] T_MEM_LAST  = 3'h2;
    localparam logic [2:0] T_IDLE_LAST = 3'h0;
    localparam logic [2:0] T_ACK_LAST  = 3'h4;

    // Strobe patterns {rd, wr, memory_request_n, io_request_n, m1, halt, status}
    localparam logic [6:0] STB_FETCH1  = 7'h2A;
    localparam logic [6:0] STB_FETCH2  = 7'h2B;
    localparam logic [6:0] STB_READ    = 7'h2F;
    localparam logic [6:0] STB_RD_HALT = 7'h2D;
    localparam logic [6:0] STB_WRITE   = 7'h4F;
    localparam logic [6:0] STB_ACK     = 7'h72;
    localparam logic [6:0] STB_INTRESP = 7'h7E;
    localparam logic [6:0] STB_QUIET   = 7'h7F;

    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET = 8'h00;

endpackage : bus_seq_pkg

// ---- dv/memory_io_model.sv ----
// Behavioural external memory and interrupting peripheral on the far side.
// Assumes it sees the sequencer's address and strobes on the same clock.
`timescale 1ns/100ps
`default_nettype none

module memory_io_model #(
    parameter logic [7:0] ACK_VECTOR = 8'h22
) (
    input  wire logic        clk,
    input  wire logic [15:0] addr,
    input  wire logic        rd_n,
    input  wire logic        memory_request_n_n,
    input  wire logic        io_request_n_n,
    input  wire logic        m1_n,
    output var  logic [7:0]  data
);
    logic [7:0] last_reg;

    // Memory byte is a fold of its address; released bus keeps toggling
    always_comb begin
        if (!rd_n && !memory_request_n_n)
            data = addr[7:0] ^ addr[15:8] ^ 8'h5A;
        else if (!io_request_n_n && !m1_n)
            data = ACK_VECTOR;
        else
            data = ~last_reg;
    end

    // Last driven value, so a floating bus never looks held
    always_ff @(posedge clk) begin
        last_reg <= data;
    end
endmodule : memory_io_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the bus cycle sequencer, one task per scenario.
// Assumes the memory model answers reads; core inputs held as constants.
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic [15:0] PC_V = 16'h1230;
    localparam logic [15:0] SP_V = 16'h8000;
    localparam logic [15:0] SW_V = 16'hBEEF;
    localparam logic [7:0]  VB_V = 8'h40;
    localparam logic [7:0]  IV_V = 8'h10;
    localparam logic [7:0]  AV_V = 8'h22;

    logic        clk, rst, start, cond_true, bus_req_n, refresh_req;
    logic [2:0]  seq_sel;
    logic [15:0] addr, captured_word;
    logic [7:0]  data_in, data_out;
    logic        data_oe, rd_n, wr_n, memory_request_n_n, io_request_n_n, m1_n, halt_n;
    logic        status_out, bus_ack_n, refresh_n, ready;
    int          fails, samples_checked;
    logic [31:0] exp_q[$];

    bus_cycle_sequencer uut (
        .CLK(clk), .RST(rst), .START(start), .SEQ_SEL(seq_sel),
        .COND_TRUE(cond_true), .PC(PC_V), .SP(SP_V), .STORE_WORD(SW_V),
        .VECTOR_BASE(VB_V), .INT_VECTOR(IV_V), .DATA_IN(data_in),
        .BUS_REQ_N(bus_req_n), .REFRESH_REQ(refresh_req), .ADDR(addr),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .RD_N(rd_n), .WR_N(wr_n),
        .MEMORY_REQUEST_N(memory_request_n_n), .IO_REQUEST_N(io_request_n_n),
        .OPCODE_CYCLE_N(m1_n), .HALT_N(halt_n), .STATUS_OUT(status_out),
        .BUS_ACK_N(bus_ack_n), .REFRESH_N(refresh_n), .READY(ready),
        .CAPTURED_WORD(captured_word));

    memory_io_model #(.ACK_VECTOR(AV_V)) mem_model (
        .clk(clk), .addr(addr), .rd_n(rd_n), .memory_request_n_n(memory_request_n_n),
        .io_request_n_n(io_request_n_n), .m1_n(m1_n), .data(data_in));

    // Same fold as the memory model, kept here on purpose
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : mem

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask : check

    // One expected entry per state: {oe, strobes, data, address}
    task automatic add(input logic [6:0] stb, input logic [15:0] a,
                       input logic [7:0] d, input int n);
        repeat (n) exp_q.push_back({~stb[5], stb, d, a});
    endtask : add

    // Start one sequence, record every state until ready, compare
    task automatic run(input logic [2:0] sel, input logic c);
        logic [31:0] got[$];
        @(posedge clk);
        start     <= 1'b1;
        seq_sel   <= sel;
        cond_true <= c;
        @(posedge clk);
        start <= 1'b0;
        // First machine cycle stands right after the taking edge
        repeat (40) begin
            #1;
            if (ready === 1'b1)
                break;
            got.push_back({data_oe, rd_n, wr_n, memory_request_n_n, io_request_n_n, m1_n,
                           halt_n, status_out, data_out, addr});
            @(posedge clk);
        end
        check(32'(got.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            check(i < got.size() ? got[i] : 32'hX, exp_q[i]);
        exp_q.delete();
    endtask : run

    task automatic t_store_hl;
        logic [15:0] mn;
        mn = {mem(PC_V + 16'h2), mem(PC_V + 16'h1)};
        add(7'h2A, PC_V, 8'h00, 3);
        add(7'h2F, PC_V + 16'h1, 8'h00, 3);
        add(7'h2F, PC_V + 16'h2, 8'h00, 3);
        add(7'h7F, 16'h0000, 8'h00, 1);
        add(7'h4F, mn, SW_V[7:0], 3);
        add(7'h4F, mn + 16'h1, SW_V[15:8], 3);
        run(3'h0, 1'b0);
    endtask : t_store_hl

    task automatic t_store_pair;
        logic [15:0] mn;
        mn = {mem(PC_V + 16'h3), mem(PC_V + 16'h2)};
        add(7'h2A, PC_V, 8'h00, 3);
        add(7'h2B, PC_V + 16'h1, 8'h00, 3);
        add(7'h2F, PC_V + 16'h2, 8'h00, 3);
        add(7'h2F, PC_V + 16'h3, 8'h00, 3);
        add(7'h7F, 16'h0000, 8'h00, 1);
        add(7'h4F, mn, SW_V[7:0], 3);
        add(7'h4F, mn + 16'h1, SW_V[15:8], 3);
        run(3'h1, 1'b0);
    endtask : t_store_pair

    task automatic t_push_index;
        add(7'h2A, PC_V, 8'h00, 3);
        add(7'h2B, PC_V + 16'h1, 8'h00, 3);
        add(7'h7F, 16'h0000, 8'h00, 2);
        add(7'h4F, SP_V - 16'h1, SW_V[15:8], 3);
        add(7'h4F, SP_V - 16'h2, SW_V[7:0], 3);
        run(3'h2, 1'b0);
    endtask : t_push_index

    // Return, then the two stack bytes show up in the captured word
    task automatic t_return;
        add(7'h2A, PC_V, 8'h00, 3);
        add(7'h2F, SP_V, 8'h00, 3);
        add(7'h2F, SP_V + 16'h1, 8'h00, 3);
        run(3'h3, 1'b0);
        @(posedge clk);
        #1;
        check({16'h0, captured_word},
              {16'h0, mem(SP_V + 16'h1), mem(SP_V)});
    endtask : t_return

    // Both outcomes of the conditional return, back to back
    task automatic t_return_cond;
        add(7'h2A, PC_V, 8'h00, 3);
        add(7'h7F, 16'h0000, 8'h00, 2);
        run(3'h4, 1'b0);
        add(7'h2A, PC_V, 8'h00, 3);
        add(7'h7F, 16'h0000, 8'h00, 1);
        add(7'h2F, SP_V, 8'h00, 3);
        add(7'h2F, SP_V + 16'h1, 8'h00, 3);
        run(3'h4, 1'b1);
    endtask : t_return_cond

    task automatic t_return_int;
        add(7'h2A, PC_V, 8'h00, 3);
        add(7'h2B, PC_V + 16'h1, 8'h00, 3);
        add(7'h2D, SP_V, 8'h00, 3);
        add(7'h2F, SP_V + 16'h1, 8'h00, 3);
        run(3'h5, 1'b0);
    endtask : t_return_int

    // Interrupt entry; first cycle pattern and vector differ by source
    task automatic t_interrupt(input logic [2:0] sel, input logic [6:0] stb,
                               input logic [7:0] vec);
        add(stb, PC_V, 8'h00, 5);
        add(7'h7F, 16'h0000, 8'h00, 1);
        add(7'h4F, SP_V - 16'h1, PC_V[15:8], 3);
        add(7'h4F, SP_V - 16'h2, PC_V[7:0], 3);
        add(7'h2F, {VB_V, vec}, 8'h00, 3);
        add(7'h2F, {VB_V, vec} + 16'h1, 8'h00, 3);
        run(sel, 1'b0);
    endtask : t_interrupt

    // Lone refresh must pulse, else the discard check below proves nothing
    task automatic t_refresh;
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        refresh_req <= 1'b1;
        @(posedge clk);
        refresh_req <= 1'b0;
        repeat (5) begin
            @(posedge clk);
            #1;
            if (refresh_n === 1'b0)
                seen = 1'b1;
        end
        check({31'h0, seen}, 32'h1);
    endtask : t_refresh

    // Bus and refresh requests both pending when a return ends
    task automatic t_arbitrate;
        logic ack_seen, ref_seen;
        ack_seen = 1'b0;
        ref_seen = 1'b0;
        @(posedge clk);
        start   <= 1'b1;
        seq_sel <= 3'h3;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        bus_req_n   <= 1'b0;
        refresh_req <= 1'b1;
        @(posedge clk);
        refresh_req <= 1'b0;
        repeat (20) begin
            @(posedge clk);
            #1;
            if (bus_ack_n === 1'b0)
                ack_seen = 1'b1;
            if (refresh_n === 1'b0)
                ref_seen = 1'b1;
        end
        check({30'h0, ack_seen, ref_seen}, 32'h2);
        @(posedge clk);
        bus_req_n <= 1'b1;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (ready === 1'b1 && bus_ack_n === 1'b1)
                break;
        end
        check({30'h0, ready, bus_ack_n}, 32'h3);
    endtask : t_arbitrate

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Whole run is a few hundred cycles; this bound is generous
    initial begin
        #50000;
        fails++;
        give_verdict();
    end

    initial begin
        rst             = 1'b1;
        start           = 1'b0;
        seq_sel         = 3'h0;
        cond_true       = 1'b0;
        bus_req_n       = 1'b1;
        refresh_req     = 1'b0;
        fails           = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_store_hl();
        t_store_pair();
        t_push_index();
        t_return();
        t_return_cond();
        t_return_int();
        t_interrupt(3'h6, 7'h72, AV_V);
        t_interrupt(3'h7, 7'h7E, IV_V);
        t_refresh();
        t_arbitrate();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
